// [psp_port.sv]
/*
  Parallel slave port with three-pin control port, reached over APB.
  Assumes pins are split into in/out/enable; the bench resolves the wires.
*/
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module psp_port
  import psp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  // APB slave
  input  wire psp_pkg::psp_apb_req_t apb_req,
  output      psp_pkg::psp_apb_rsp_t apb_rsp,
  // Data port pins
  input  wire logic [7:0]    data_pin_i,
  output      psp_pkg::psp_data_drv_t data_drv,
  // Control port pins
  input  wire logic [2:0]    ctrl_pin_i,
  output      psp_pkg::psp_ctrl_drv_t ctrl_drv,
  // Transfer event flag
  output      logic          slave_port_irq_flag
);
  import psp_pkg::*;

  psp_state_t s_q;
  psp_state_t s_d;

  logic       setup_ph;
  logic       wr_acc;
  logic       rd_acc;
  logic       rd_n;
  logic       wr_n;
  logic       cs_n;
  logic       ext_wr;
  logic       ext_rd;
  logic [2:0] cpins_rd;
  logic [7:0] csdir_rd;

  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
  assign rd_acc   = apb_req.psel & apb_req.penable & ~apb_req.pwrite & clk_en;

  // Strobes as seen after the two-stage synchroniser
  assign rd_n   = s_q.csync2[0];
  assign wr_n   = s_q.csync2[1];
  assign cs_n   = s_q.csync2[2];
  assign ext_wr = s_q.mode & ~cs_n & ~wr_n;
  assign ext_rd = s_q.mode & ~cs_n & ~rd_n;

  assign cpins_rd = s_q.csync2 & ~s_q.ansel;
  assign csdir_rd = {s_q.input_full_flag, s_q.output_full_flag, s_q.input_overflow_flag, s_q.mode, 1'b0, s_q.cdir};

  always_comb begin
    s_d = s_q;
    s_d.dsync1 = data_pin_i;
    s_d.dsync2 = s_q.dsync1;
    s_d.csync1 = ctrl_pin_i;
    s_d.csync2 = s_q.csync1;
    s_d.irq    = 1'b0;

    // External transfer edge detection
    case (s_q.xfer)
      PSP_IDLE: begin
        if (ext_wr) begin
          s_d.xfer  = PSP_WRITE;
          s_d.inbuf = s_q.dsync2;
          if (s_q.input_full_flag) begin
            s_d.input_overflow_flag = 1'b1;
          end
          s_d.input_full_flag = 1'b1;
          s_d.irq = 1'b1;
        end else if (ext_rd) begin
          s_d.xfer = PSP_READ;
          s_d.output_full_flag  = 1'b0;
          s_d.irq  = 1'b1;
        end
      end
      PSP_WRITE: begin
        if (!ext_wr) begin
          s_d.xfer = PSP_IDLE;
        end
      end
      PSP_READ: begin
        if (!ext_rd) begin
          s_d.xfer = PSP_IDLE;
        end
      end
      default: begin
        s_d.xfer = PSP_IDLE;
      end
    endcase

    // Register writes
    if (wr_acc) begin
      case (apb_req.paddr)
        `PSP_OFF_DPORT, `PSP_OFF_DLATCH: begin
          s_d.dlatch = apb_req.pwdata[7:0];
          if (s_q.mode) begin
            s_d.output_full_flag = 1'b1;
          end
        end
        `PSP_OFF_DDIR: s_d.ddir = apb_req.pwdata[7:0];
        `PSP_OFF_CPINS, `PSP_OFF_CLATCH: s_d.clatch = apb_req.pwdata[2:0];
        `PSP_OFF_CSDIR: begin
          s_d.cdir = apb_req.pwdata[2:0];
          s_d.mode = apb_req.pwdata[`PSP_BIT_MODE];
          // Overflow only clears by software; a new overflow wins
          if (!apb_req.pwdata[`PSP_BIT_INPUT_OVERFLOW_FLAG] && !(s_q.xfer == PSP_IDLE && ext_wr && s_q.input_full_flag)) begin
            s_d.input_overflow_flag = 1'b0;
          end
        end
        `PSP_OFF_ANSEL: s_d.ansel = apb_req.pwdata[2:0];
        default: ;
      endcase
    end

    // Processor read of data port empties input buffer; external write wins
    if (rd_acc && apb_req.paddr == `PSP_OFF_DPORT && s_q.mode
        && !(s_q.xfer == PSP_IDLE && ext_wr)) begin
      s_d.input_full_flag = 1'b0;
    end

    // Read data captured at setup
    if (setup_ph && clk_en) begin
      case (apb_req.paddr)
        `PSP_OFF_DPORT:  s_d.prdata = {24'h000000, s_q.mode ? s_q.inbuf : s_q.dsync2};
        `PSP_OFF_DLATCH: s_d.prdata = {24'h000000, s_q.dlatch};
        `PSP_OFF_DDIR:   s_d.prdata = {24'h000000, s_q.ddir};
        `PSP_OFF_CPINS:  s_d.prdata = {29'h00000000, cpins_rd};
        `PSP_OFF_CLATCH: s_d.prdata = {29'h00000000, s_q.clatch};
        `PSP_OFF_CSDIR:  s_d.prdata = {24'h000000, csdir_rd};
        `PSP_OFF_ANSEL:  s_d.prdata = {29'h00000000, s_q.ansel};
        `PSP_OFF_IRQ:    s_d.prdata = {31'h00000000, s_q.irq};
        default:         s_d.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.ddir   <= `PSP_RST_DDIR;
      s_q.cdir   <= `PSP_RST_CDIR;
      // Strobes idle high, so no false event follows reset
      s_q.csync1 <= `PSP_RST_STROBES;
      s_q.csync2 <= `PSP_RST_STROBES;
      s_q.xfer   <= PSP_IDLE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign apb_rsp.prdata  = s_q.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = 1'b0;

  // In slave mode the data bus drives only during an external read
  assign data_drv.o  = s_q.mode ? s_q.dlatch : s_q.dlatch;
  assign data_drv.oe = s_q.mode ? {8{ext_rd}} : ~s_q.ddir;

  assign ctrl_drv.o  = s_q.clatch;
  assign ctrl_drv.oe = ~s_q.cdir;

  assign slave_port_irq_flag = s_q.irq;

  // Assertions
  chk_ctrl_dir: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_drv.oe == ~s_q.cdir) else $error("control enable not inverse of direction");
  chk_wr_sets_ibf: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.xfer == PSP_IDLE && ext_wr |=> s_q.input_full_flag && slave_port_irq_flag)
    else $error("external write did not set input full");
  chk_rd_clr_obf: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.xfer == PSP_IDLE && !ext_wr && ext_rd && !wr_acc |=> !s_q.output_full_flag)
    else $error("external read did not clear output full");
  chk_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.xfer == PSP_IDLE && ext_wr && s_q.input_full_flag |=> s_q.input_overflow_flag)
    else $error("overflow not flagged");
  chk_one_event: assert property (@(posedge pclk) disable iff (!presetn)
    slave_port_irq_flag |=> !slave_port_irq_flag || $past(clk_en) == 1'b0)
    else $error("event flag held over a transfer");
  chk_bit3_zero: assert property (@(posedge pclk) disable iff (!presetn)
    csdir_rd[3] == 1'b0) else $error("bit 3 not zero");
  chk_ansel_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (cpins_rd & s_q.ansel) == 3'h0) else $error("analog pin read nonzero");
  chk_obf_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && apb_req.paddr == `PSP_OFF_DLATCH && s_q.mode |=> s_q.output_full_flag)
    else $error("processor write did not set output full");
  chk_ctrl_out: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_drv.o == s_q.clatch) else $error("control pin not driven from latch");


  // Event flag for a read transfer
  chk_rd_event: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.xfer == PSP_IDLE && ext_rd |=> slave_port_irq_flag)
    else $error("external read raised no event");

  // Held strobes give one event only
  chk_first_low: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.xfer != PSP_IDLE |=> !slave_port_irq_flag)
    else $error("event repeated while strobe held");

  // No events outside slave mode
  chk_gpio_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !s_q.mode |=> !slave_port_irq_flag)
    else $error("event outside slave mode");

  // Written byte comes from the synchronised pins
  chk_inbuf_cap: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.xfer == PSP_IDLE && ext_wr |=> s_q.inbuf == $past(s_q.dsync2))
    else $error("input latch not captured from pins");

  // Input full holds until the processor reads the data port
  chk_ibf_held: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.input_full_flag && !(rd_acc && apb_req.paddr == `PSP_OFF_DPORT) |=> s_q.input_full_flag)
    else $error("input full dropped without a read");

  // Processor read of the data port empties the input
  chk_ibf_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rd_acc && apb_req.paddr == `PSP_OFF_DPORT && s_q.mode
    && !(s_q.xfer == PSP_IDLE && ext_wr) |=> !s_q.input_full_flag)
    else $error("input full not cleared by read");

  // Output full holds until an external read
  chk_obf_held: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.output_full_flag && !(s_q.xfer == PSP_IDLE && ext_rd && !ext_wr) |=> s_q.output_full_flag)
    else $error("output full dropped without a read");

  // Overflow is sticky until software writes zero
  chk_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.input_overflow_flag && !(wr_acc && apb_req.paddr == `PSP_OFF_CSDIR
    && !apb_req.pwdata[`PSP_BIT_INPUT_OVERFLOW_FLAG]) |=> s_q.input_overflow_flag)
    else $error("overflow cleared without software");

  // Mode bit follows the register write
  chk_mode_wr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && apb_req.paddr == `PSP_OFF_CSDIR
    |=> s_q.mode == $past(apb_req.pwdata[`PSP_BIT_MODE]))
    else $error("mode bit not written");

  // Direction bits follow the register write
  chk_dir_wr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && apb_req.paddr == `PSP_OFF_CSDIR
    |=> s_q.cdir == $past(apb_req.pwdata[2:0]))
    else $error("direction bits not written");

  // Control latch keeps the written value, not the pins
  chk_clatch_wr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && apb_req.paddr == `PSP_OFF_CLATCH
    |=> s_q.clatch == $past(apb_req.pwdata[2:0]))
    else $error("control latch not written");

  // Data bus driven from the latch during an external read
  chk_slave_drive: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.mode && ext_rd |-> data_drv.oe == 8'hFF && data_drv.o == s_q.dlatch)
    else $error("data bus not driven on read");

  // Data bus released otherwise in slave mode
  chk_slave_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.mode && !ext_rd |-> data_drv.oe == 8'h00)
    else $error("data bus driven outside a read");

  cov_ext_write: cover property (@(posedge pclk) disable iff (!presetn) s_q.xfer == PSP_WRITE);
  cov_ext_read:  cover property (@(posedge pclk) disable iff (!presetn) s_q.xfer == PSP_READ);
  cov_overflow:  cover property (@(posedge pclk) disable iff (!presetn) s_q.input_overflow_flag);
  cov_cpu_read:  cover property (@(posedge pclk) disable iff (!presetn)
    rd_acc && apb_req.paddr == `PSP_OFF_DPORT && s_q.mode && s_q.input_full_flag);
  cov_gpio_out:  cover property (@(posedge pclk) disable iff (!presetn)
    !s_q.mode && ctrl_drv.oe != 3'h0);
endmodule : psp_port

// [psp_defines.svh]
/*
  Register offsets, field positions and reset values for the parallel slave port block.
  Assumes inclusion by the package and the bench; definitions only.
*/
// Contract
// - Three control pins, each set independently as input or output.
// - Read of control latch register returns latch value, not pin levels.
// - Direction bit 1 makes control pin an input, driver off.
// - Direction bit 0 makes control pin drive its latch value.
// - Control pins selected as analog inputs read as zero.
// - Direction bits keep controlling pin direction even in analog use.
// - Bit 7 read-only: input word waiting for the processor.
// - Bit 6 read-only: output word still unread by external master.
// - Bit 5 set on external write while input unread; software clears.
// - Bit 4 selects slave port mode when 1, plain I/O when 0.
// - Bit 3 unimplemented, always reads zero.
// - Slave mode: pin0 read strobe, pin1 write strobe, pin2 chip select.
// - Write registered when chip select and write strobe first both low.
// - Read registered when chip select and read strobe first both low.
// - External master reads and writes data latch as one 8-bit latch; the code captures writes into inbuf and drives reads from dlatch.
// - External accesses are asynchronous to the clock in slave mode.
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

`define PSP_OFF_DPORT   12'h000
`define PSP_OFF_DLATCH  12'h004
`define PSP_OFF_DDIR    12'h008
`define PSP_OFF_CPINS   12'h00C
`define PSP_OFF_CLATCH  12'h010
`define PSP_OFF_CSDIR   12'h014
`define PSP_OFF_ANSEL   12'h018
`define PSP_OFF_IRQ     12'h01C

`define PSP_BIT_IBF     7
`define PSP_BIT_OBF     6
`define PSP_BIT_INPUT_OVERFLOW_FLAG    5
`define PSP_BIT_MODE    4

`define PSP_RST_DDIR    8'hFF
`define PSP_RST_CDIR    3'h7
`define PSP_RST_BYTE    8'h00
`define PSP_RST_CTRL    3'h0
`define PSP_RST_STROBES 3'h7

`endif

// [psp_pkg.sv]
/*
  Types shared by the parallel slave port block.
  Assumes psp_defines.svh is in the include path.
*/
package psp_pkg;
  `include "psp_defines.svh"

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } psp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } psp_apb_rsp_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } psp_data_drv_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } psp_ctrl_drv_t;

  typedef enum logic [1:0] {
    PSP_IDLE  = 2'b00,
    PSP_WRITE = 2'b01,
    PSP_READ  = 2'b10
  } psp_xfer_t;

  typedef struct packed {
    logic [7:0] dlatch;
    logic [7:0] ddir;
    logic [2:0] clatch;
    logic [2:0] cdir;
    logic       mode;
    logic       input_full_flag;
    logic       output_full_flag;
    logic       input_overflow_flag;
    logic [7:0] inbuf;
    logic [2:0] ansel;
    logic       irq;
    logic [7:0] dsync1;
    logic [7:0] dsync2;
    logic [2:0] csync1;
    logic [2:0] csync2;
    psp_xfer_t  xfer;
    logic [31:0] prdata;
  } psp_state_t;
endpackage : psp_pkg

// [psp_host_model.sv]
/* External byte-wide bus master model driving strobes and data.
   Assumes the bench resolves pin levels against the port's drivers. */
`timescale 1ns/1ps
module psp_host_model (
  // Clock and resolved data bus
  input  wire logic       pclk,
  input  wire logic [7:0] data_i,
  // Driven levels: bit0 read, bit1 write, bit2 select
  output      logic [2:0] ctrl_o,
  output      logic [7:0] data_o
);
  initial begin
    ctrl_o = 3'h7;
    data_o = 8'h00;
  end
  // Data settles 3 cycles ahead; stale data inverted after hold
  task automatic ext_write(input logic [7:0] b);
    @(posedge pclk) data_o <= b;
    repeat (3) @(posedge pclk);
    ctrl_o <= 3'b001;
    repeat (4) @(posedge pclk);
    ctrl_o <= 3'h7;
    repeat (3) @(posedge pclk);
    data_o <= ~b;
  endtask : ext_write
  task automatic ext_read(output logic [7:0] b);
    @(posedge pclk) ctrl_o <= 3'b010;
    repeat (4) @(posedge pclk);
    b = data_i;
    ctrl_o <= 3'h7;
    repeat (3) @(posedge pclk);
  endtask : ext_read
endmodule : psp_host_model

// [parallel_slave_port_with_ctrl_io_tb.sv]
/* Self-checking bench for the slave port over APB and the pin model.
   Assumes psp_pkg and psp_defines.svh are compiled and on the path. */
`timescale 1ns/1ps
`include "psp_defines.svh"
module parallel_slave_port_with_ctrl_io_tb;
  import psp_pkg::*;
  logic          pclk, presetn, irq;
  psp_apb_req_t  req;
  psp_apb_rsp_t  rsp;
  psp_data_drv_t ddrv;
  psp_ctrl_drv_t cdrv;
  logic [7:0]    hd, dpin, b;
  logic [2:0]    hc, cpin;
  logic [31:0]   rd;
  int            miscompares, samples_checked, irq_n;
  assign dpin = (ddrv.oe & ddrv.o) | (~ddrv.oe & hd);
  assign cpin = (cdrv.oe & cdrv.o) | (~cdrv.oe & hc);
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (irq === 1'b1) irq_n++;
  psp_port psp_port_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .apb_req(req), .apb_rsp(rsp),
    .data_pin_i(dpin), .data_drv(ddrv), .ctrl_pin_i(cpin), .ctrl_drv(cdrv), .slave_port_irq_flag(irq));
  psp_host_model psp_host_model_i (.pclk(pclk), .data_i(dpin), .ctrl_o(hc), .data_o(hd));
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (rsp.pready === 1'b1) break;
    end
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n == 50) begin
      miscompares++;
      close_out();
    end
    // Let the accepted edge settle before outputs are looked at
    @(negedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  initial begin
    presetn = 1'b0;
    req = '0;
    miscompares = 0;
    samples_checked = 0;
    irq_n = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(`PSP_OFF_CSDIR, 32'h07);
    rc(`PSP_OFF_DDIR, 32'hFF);
    rc(12'h020, 32'h0);
    // Pin 1 input, pins 0 and 2 drive latch
    wr(`PSP_OFF_CLATCH, 32'h5);
    wr(`PSP_OFF_CSDIR, 32'h0A);
    chk(cdrv.oe, 32'h5);
    chk(cdrv.o, 32'h5);
    rc(`PSP_OFF_CPINS, 32'h7);
    rc(`PSP_OFF_CLATCH, 32'h5);
    rc(`PSP_OFF_CSDIR, 32'h02);
    // Only the input pin goes analog
    wr(`PSP_OFF_ANSEL, 32'h2);
    rc(`PSP_OFF_CPINS, 32'h5);
    chk(cdrv.oe, 32'h5);
    wr(`PSP_OFF_ANSEL, 32'h0);
    // Slave mode with all control pins as inputs
    wr(`PSP_OFF_CSDIR, 32'h17);
    wr(`PSP_OFF_DPORT, 32'hA5);
    rc(`PSP_OFF_CSDIR, 32'h57);
    psp_host_model_i.ext_read(b);
    chk(b, 32'hA5);
    rc(`PSP_OFF_CSDIR, 32'h17);
    psp_host_model_i.ext_write(8'h3C);
    rc(`PSP_OFF_CSDIR, 32'h97);
    psp_host_model_i.ext_write(8'hC3);
    rc(`PSP_OFF_CSDIR, 32'hB7);
    rc(`PSP_OFF_DPORT, 32'hC3);
    rc(`PSP_OFF_CSDIR, 32'h37);
    wr(`PSP_OFF_CSDIR, 32'h17);
    rc(`PSP_OFF_CSDIR, 32'h17);
    // Strobes ignored once slave mode is off
    wr(`PSP_OFF_CSDIR, 32'h07);
    psp_host_model_i.ext_write(8'h55);
    rc(`PSP_OFF_CSDIR, 32'h07);
    chk(irq_n, 32'd3);
    close_out();
  end
endmodule : parallel_slave_port_with_ctrl_io_tb
